// File: include/dtp_map.vh
// Purpose: Register offsets, fields and reset values of the dual pulse unit
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Definitions only
`ifndef DTP_MAP_VH
`define DTP_MAP_VH
`define DTP_ADDR_W 8
`define DTP_OFS_CTRL_ONE 8'h05
`define DTP_OFS_CTRL_TWO 8'h06
`define DTP_OFS_PERIOD_ONE 8'h07
`define DTP_OFS_PERIOD_TWO 8'h08
`define DTP_OFS_DUTY_ONE 8'h09
`define DTP_OFS_DUTY_TWO 8'h0a
`define DTP_OFS_COUNTER_ONE 8'h0b
`define DTP_OFS_COUNTER_TWO 8'h0c
`define DTP_OFS_OPTION_TWO 8'h0d
`define DTP_CTRL_ON_BIT 7
`define DTP_CTRL_PS_HI 5
`define DTP_CTRL_PS_LO 4
`define DTP_CTRL_WMASK 8'hb3
`define DTP_OPT_DEFEN_BIT 2
`define DTP_PERIOD_RST 8'hff
`define DTP_CTRL_RST 8'h00
`define DTP_OPT_RST 8'h00
`define DTP_LOSS_LIMIT 3'h4
`define DTP_PS_MAX 4'hf
`endif

// File: hw/dtp_unit.v
// Purpose: Two pulse-width channels with 8-bit timers and prescalers
// Assumes: One clock; register port strobes are synchronous to clk_i
// Notes: Counter timebase is clk_i divided by four, then by prescale
// Notes: Pins stay undriven until configuration is loaded
`timescale 1ns/1ps
`default_nettype none
`include "dtp_map.vh"
// Operation
// - Two separately enabled pulse channels, each on own pin, ten-bit duty.
// - Outputs stay disabled until self-configuration loading has finished.
// - With default feature on, four transmissions without receive force defaults.
// - Default action disables the channel and forces pin low, high or float.
// - Each channel has readable writable 8-bit counter, cleared on reset or off.
// - Counter counts clock over four, then over one, four or sixteen.
// - Prescale code 00 is one, 01 is four, 1x is sixteen.
// - Counter counts from zero to period limit, then wraps to zero.
// - Period registers reset to all ones.
// - Control bit 7 starts and stops the counter.
// - Prescaler cleared by control or counter writes and by resets.
// - Period is limit plus one, times four clocks, times prescale.
// - On match, next step clears counter and loads duty shadow.
// - Duty is duty byte high eight bits, control bits 1:0 low.
// - Duty writes take effect only after the current period ends.
// - Duty double-buffered in shadow byte plus two-bit latch.
// - Pin goes low when shadow duty equals counter with quarter or prescaler bits.
// - Duty beyond period never drives the pin low that period.
// - High time is duty times clock period times prescale.
// - Power-on clears on and prescale bits; pin reset keeps duty bits.
// - Control bits 6, 3 and 2 read as zero.
// - Option bit 2 enables the loss-of-communication default feature.
module dtp_unit #(
  parameter [1:0] DEF_MODE_ONE = 2'b00,
  parameter [1:0] DEF_MODE_TWO = 2'b00
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire pin_rst_n_i,
  input wire config_done_i,
  input wire rx_valid_i,
  input wire tx_sched_i,
  input wire wr_i,
  input wire rd_i,
  input wire [`DTP_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg pulse_pin_one_o,
  output reg pulse_pin_one_oe_o,
  output reg pulse_pin_two_o,
  output reg pulse_pin_two_oe_o,
  output reg comm_lost_o
);
  // Default pin modes: 00 low, 01 high, 1x high impedance
  // Synchroniser stages for the reset, pin reset and done inputs
  reg rst_s1;
  reg rst_s2;
  reg pin_s1;
  reg pin_s2;
  reg done_s1;
  reg done_s2;
  reg cfg_done;

  // Per-channel register file
  reg [7:0] ctrl [0:1];
  reg [7:0] period_limit [0:1];
  reg [7:0] duty_high_byte [0:1];

  // Double buffer of the duty value
  reg [7:0] duty_shadow_byte [0:1];
  reg [1:0] duty_low_latch [0:1];

  // Timebase state
  reg [7:0] channel_counter [0:1];
  reg [3:0] prescale [0:1];
  reg [1:0] quarter [0:1];
  reg wrap_pend [0:1];
  reg pin_level [0:1];

  // Global option and loss watchdog
  reg [7:0] option_two;
  reg [2:0] loss_count;
  reg [7:0] next_rdata;
  integer i;
  integer j;

  // Default mode code that drives the pin high
  localparam [1:0] MODE_HIGH = 2'b01;

  // Write strobe decode for one register offset
  function wr_hit;
    input we;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = we && (addr == ofs);
    end
  endfunction

  // Prescaler terminal count per code
  function [3:0] ps_limit;
    input [1:0] code;
    begin
      if (code[1])
        ps_limit = `DTP_PS_MAX;
      else if (code[0])
        ps_limit = 4'h3;
      else
        ps_limit = 4'h0;
    end
  endfunction

  // Extra low bits of the compare from prescaler or quarter clock
  function [1:0] fine_bits;
    input [1:0] code;
    input [3:0] ps;
    input [1:0] q;
    begin
      if (code[1])
        fine_bits = ps[3:2];
      else if (code[0])
        fine_bits = ps[1:0];
      else
        fine_bits = q;
    end
  endfunction

  // Reset release synchroniser; pin reset is synchronised on assertion and release alike
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      // Only the second stage reads the first
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
    end
    else
    begin
      // Pin reset and done are level inputs from pins
      pin_s1 <= pin_rst_n_i;
      pin_s2 <= pin_s1;
      done_s1 <= config_done_i;
      done_s2 <= done_s1;
    end
  end

  // Pin reset acts only once synchronised
  wire rst_any = !pin_s2;
  wire feat_on = option_two[`DTP_OPT_DEFEN_BIT];
  wire loss_hit = feat_on && tx_sched_i && !rx_valid_i &&
    (loss_count == `DTP_LOSS_LIMIT - 3'h1);

  // Loss-of-communication watchdog counts scheduled transmissions
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      loss_count <= 3'h0;
      comm_lost_o <= 1'b0;
      cfg_done <= 1'b0;
    end
    else
    begin
      // Configuration done is sticky
      if (done_s2)
        cfg_done <= 1'b1;

      // Saturates so a long outage cannot wrap back to zero
      if (rst_any || !feat_on || rx_valid_i)
        loss_count <= 3'h0;
      else if (tx_sched_i && loss_count != `DTP_LOSS_LIMIT)
        loss_count <= loss_count + 3'h1;

      // Flag holds until a valid message arrives or a pin reset
      if (rst_any || rx_valid_i)
        comm_lost_o <= 1'b0;
      else if (loss_hit)
        comm_lost_o <= 1'b1;
    end
  end

  // Duty bytes and duty low bits are not reset by design
  always @(posedge clk_i)
  begin
    // Own loop index, so no variable is shared between processes
    for (j = 0; j < 2; j = j + 1)
    begin
      if (wr_hit(wr_i, addr_i, `DTP_OFS_DUTY_ONE + j[7:0]))
        duty_high_byte[j] <= wdata_i;
      if (wrap_pend[j])
      begin
        duty_shadow_byte[j] <= duty_high_byte[j];
        duty_low_latch[j] <= ctrl[j][1:0];
      end
    end
  end

  // Timers, prescalers and control; pin reset keeps the duty low bits
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      option_two <= `DTP_OPT_RST;
      for (i = 0; i < 2; i = i + 1)
      begin
        ctrl[i] <= `DTP_CTRL_RST;
        period_limit[i] <= `DTP_PERIOD_RST;
        channel_counter[i] <= 8'h00;
        prescale[i] <= 4'h0;
        quarter[i] <= 2'h0;
        wrap_pend[i] <= 1'b0;
        pin_level[i] <= 1'b0;
      end
    end
    else if (rst_any)
    begin
      // Like power-on, except that the duty bits survive
      option_two <= `DTP_OPT_RST;
      for (i = 0; i < 2; i = i + 1)
      begin
        ctrl[i] <= {6'h00, ctrl[i][1:0]};
        period_limit[i] <= `DTP_PERIOD_RST;
        channel_counter[i] <= 8'h00;
        prescale[i] <= 4'h0;
        quarter[i] <= 2'h0;
        wrap_pend[i] <= 1'b0;
        pin_level[i] <= 1'b0;
      end
    end
    else
    begin
      if (wr_i && addr_i == `DTP_OFS_OPTION_TWO)
        option_two <= wdata_i;
      for (i = 0; i < 2; i = i + 1)
      begin
        // Quarter count is the divide-by-four timebase
        quarter[i] <= quarter[i] + 2'h1;
        // Loss default wins over a control write in the same cycle
        if (loss_hit)
          ctrl[i] <= {1'b0, ctrl[i][6:0]};
        else if (wr_i && addr_i == `DTP_OFS_CTRL_ONE + i[7:0])
          ctrl[i] <= wdata_i & `DTP_CTRL_WMASK;
        if (wr_hit(wr_i, addr_i, `DTP_OFS_PERIOD_ONE + i[7:0]))
          period_limit[i] <= wdata_i;

        if (!ctrl[i][`DTP_CTRL_ON_BIT])
        begin
          channel_counter[i] <= 8'h00;
          prescale[i] <= 4'h0;
          quarter[i] <= 2'h0;
          wrap_pend[i] <= 1'b0;
          pin_level[i] <= 1'b0;
        end
        // Prescaler steps once every four clocks
        else if (quarter[i] == 2'h3)
        begin
          if (prescale[i] >=
            ps_limit(ctrl[i][`DTP_CTRL_PS_HI:`DTP_CTRL_PS_LO]))
          begin
            prescale[i] <= 4'h0;
            if (channel_counter[i] == period_limit[i])
            begin
              channel_counter[i] <= 8'h00;
              wrap_pend[i] <= 1'b1;
            end
            else
              channel_counter[i] <= channel_counter[i] + 8'h01;
          end
          else
            prescale[i] <= prescale[i] + 4'h1;
        end

        // Shadow loads one clock after the wrap, on the same clock that sets the pin level for the new period
        if (ctrl[i][`DTP_CTRL_ON_BIT] && wrap_pend[i])
        begin
          wrap_pend[i] <= 1'b0;
          pin_level[i] <= (duty_high_byte[i] != 8'h00) ||
            (ctrl[i][1:0] != 2'h0);
        end
        // Compare uses the shadow, so mid-period writes cannot glitch
        else if (ctrl[i][`DTP_CTRL_ON_BIT] &&
          {duty_shadow_byte[i], duty_low_latch[i]} ==
          {channel_counter[i], fine_bits(
            ctrl[i][`DTP_CTRL_PS_HI:`DTP_CTRL_PS_LO],
            prescale[i], quarter[i])})
          pin_level[i] <= 1'b0;

        // Control and counter writes restart the prescaler
        if (wr_i && (addr_i == `DTP_OFS_CTRL_ONE + i[7:0] ||
          addr_i == `DTP_OFS_COUNTER_ONE + i[7:0]))
        begin
          prescale[i] <= 4'h0;
          quarter[i] <= 2'h0;
        end

        // Counter write comes last, so it wins over the run logic
        if (wr_hit(wr_i, addr_i, `DTP_OFS_COUNTER_ONE + i[7:0]))
          channel_counter[i] <= wdata_i;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (addr_i)
      `DTP_OFS_CTRL_ONE: next_rdata = ctrl[0] & `DTP_CTRL_WMASK;
      `DTP_OFS_CTRL_TWO: next_rdata = ctrl[1] & `DTP_CTRL_WMASK;
      `DTP_OFS_PERIOD_ONE: next_rdata = period_limit[0];
      `DTP_OFS_PERIOD_TWO: next_rdata = period_limit[1];
      `DTP_OFS_DUTY_ONE: next_rdata = duty_high_byte[0];
      `DTP_OFS_DUTY_TWO: next_rdata = duty_high_byte[1];
      `DTP_OFS_COUNTER_ONE: next_rdata = channel_counter[0];
      `DTP_OFS_COUNTER_TWO: next_rdata = channel_counter[1];
      `DTP_OFS_OPTION_TWO: next_rdata = option_two;
      default: next_rdata = 8'h00;
    endcase
  end

  // Pins held undriven until configuration is loaded
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      rdata_o <= 8'h00;
      pulse_pin_one_o <= 1'b0;
      pulse_pin_one_oe_o <= 1'b0;
      pulse_pin_two_o <= 1'b0;
      pulse_pin_two_oe_o <= 1'b0;
    end
    else
    begin
      // Read data stands one cycle, zero otherwise
      rdata_o <= rd_i ? next_rdata : 8'h00;
      if (!cfg_done)
      begin
        pulse_pin_one_o <= 1'b0;
        pulse_pin_one_oe_o <= 1'b0;
        pulse_pin_two_o <= 1'b0;
        pulse_pin_two_oe_o <= 1'b0;
      end
      else if (comm_lost_o)
      begin
        // Default state after lost communication
        pulse_pin_one_o <= DEF_MODE_ONE == MODE_HIGH;
        pulse_pin_one_oe_o <= !DEF_MODE_ONE[1];
        pulse_pin_two_o <= DEF_MODE_TWO == MODE_HIGH;
        pulse_pin_two_oe_o <= !DEF_MODE_TWO[1];
      end
      else
      begin
        // Running waveform while the channel is enabled
        pulse_pin_one_o <= pin_level[0];
        pulse_pin_one_oe_o <= ctrl[0][`DTP_CTRL_ON_BIT];
        pulse_pin_two_o <= pin_level[1];
        pulse_pin_two_oe_o <= ctrl[1][`DTP_CTRL_ON_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/dtp_load.sv
// Purpose: Load model timing the high and period of one pulse pin
// Assumes: Pin sampled on clk_i
// Notes: Undriven pin reads low, as through a pull-down
`timescale 1ns/1ps
`default_nettype none
module dtp_load (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output var logic [15:0] high_o,
  output var logic [15:0] period_o
);
  logic lvl;
  logic prev;
  logic [15:0] cnt;
  logic [15:0] hc;
  assign lvl = pin_i & oe_i;
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      prev <= 1'b0;
      cnt <= 16'h0000;
      hc <= 16'h0000;
      high_o <= 16'h0000;
      period_o <= 16'h0000;
    end
    else
    begin
      prev <= lvl;
      cnt <= cnt + 16'h0001;
      if (lvl)
        hc <= hc + 16'h0001;
      if (lvl && !prev)
      begin
        period_o <= cnt;
        cnt <= 16'h0001;
        hc <= 16'h0001;
      end
      if (!lvl && prev)
        high_o <= hc;
    end
endmodule
`default_nettype wire

// File: bench/dtp_unit_chk.sv
// Purpose: Port checker for the dual pulse unit
// Assumes: Default pin mode low
// Notes: Bound to every dtp_unit
`timescale 1ns/1ps
`default_nettype none
`include "dtp_map.vh"
module dtp_unit_chk (
  input wire clk_i,
  input wire rst_n_i,
  input wire config_done_i,
  input wire rx_valid_i,
  input wire tx_sched_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire pulse_pin_one_o,
  input wire pulse_pin_one_oe_o,
  input wire pulse_pin_two_o,
  input wire pulse_pin_two_oe_o,
  input wire comm_lost_o
);
  logic seen;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      seen <= 1'b0;
    else if (config_done_i)
      seen <= 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_cfg_hold;
    !seen |-> !pulse_pin_one_oe_o && !pulse_pin_two_oe_o;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("pin on early");
  property p_post_rst;
    $rose(rst_n_i) |->
      (!pulse_pin_one_oe_o && !pulse_pin_two_oe_o && !comm_lost_o)[*2];
  endproperty
  a_post_rst: assert property (p_post_rst) else $error("busy reset");
  property p_loss_pin;
    comm_lost_o[*2] |-> !pulse_pin_one_o && !pulse_pin_two_o;
  endproperty
  a_loss_pin: assert property (p_loss_pin) else $error("pin not low");
  property p_loss_cause;
    $rose(comm_lost_o) |->
      $past(tx_sched_i) || $past(tx_sched_i, 2) || $past(tx_sched_i, 3);
  endproperty
  a_loss_cause: assert property (p_loss_cause) else $error("no tx");
  property p_loss_clear;
    rx_valid_i |-> ##[1:3] !comm_lost_o;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("stuck");
  property p_ctrl_rd;
    rd_i && (addr_i == `DTP_OFS_CTRL_ONE || addr_i == `DTP_OFS_CTRL_TWO)
      |=> (rdata_o & 8'h4c) == 8'h00;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("spare bits");
  property p_ctrl_wb;
    wr_i && addr_i == `DTP_OFS_CTRL_ONE ##1 !wr_i
      ##1 rd_i && addr_i == `DTP_OFS_CTRL_ONE
      |=> rdata_o == ($past(wdata_i, 3) & 8'hb3);
  endproperty
  a_ctrl_wb: assert property (p_ctrl_wb) else $error("ctrl readback");
  property p_period_wb;
    wr_i && addr_i == `DTP_OFS_PERIOD_ONE ##1 !wr_i
      ##1 rd_i && addr_i == `DTP_OFS_PERIOD_ONE
      |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_period_wb: assert property (p_period_wb) else $error("limit rb");
endmodule
bind dtp_unit dtp_unit_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .config_done_i(config_done_i), .rx_valid_i(rx_valid_i),
  .tx_sched_i(tx_sched_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .pulse_pin_one_o(pulse_pin_one_o),
  .pulse_pin_one_oe_o(pulse_pin_one_oe_o),
  .pulse_pin_two_o(pulse_pin_two_o),
  .pulse_pin_two_oe_o(pulse_pin_two_oe_o), .comm_lost_o(comm_lost_o));
`default_nettype wire

// File: bench/tb_dtp_unit.sv
// Purpose: Register and waveform tests of the dual pulse unit
// Assumes: 50 MHz clock, default pin mode low
// Notes: Period 3 keeps runs short
`timescale 1ns/1ps
`default_nettype none
`include "dtp_map.vh"
module tb_dtp_unit;
  logic clk_i, rst_n_i, pin_rst_n_i, config_done_i, rx_valid_i;
  logic tx_sched_i, wr_i, rd_i, pin1, oe1, pin2, oe2, lost, low;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [15:0] hi1, per1, hi2, per2, ps;
  int mismatches, n_tests;
  dtp_unit DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_rst_n_i(pin_rst_n_i),
    .config_done_i(config_done_i), .rx_valid_i(rx_valid_i),
    .tx_sched_i(tx_sched_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .pulse_pin_one_o(pin1),
    .pulse_pin_one_oe_o(oe1), .pulse_pin_two_o(pin2),
    .pulse_pin_two_oe_o(oe2), .comm_lost_o(lost));
  dtp_load u_ld1 (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin1),
    .oe_i(oe1), .high_o(hi1), .period_o(per1));
  dtp_load u_ld2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin2),
    .oe_i(oe2), .high_o(hi2), .period_o(per2));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask
  task tx(input int n);
    repeat (n)
    begin
      @(posedge clk_i) tx_sched_i <= 1'b1;
      @(posedge clk_i) tx_sched_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(20 * 20000);
    mismatches++;
    results;
  end
  initial
  begin
    {rst_n_i, config_done_i, rx_valid_i, tx_sched_i, wr_i, rd_i} = 6'h00;
    pin_rst_n_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`DTP_OFS_PERIOD_ONE, 8'hff);
    rd(`DTP_OFS_PERIOD_TWO, 8'hff);
    rd(8'h20, 8'h00);
    wr(`DTP_OFS_PERIOD_ONE, 8'h3c);
    rd(`DTP_OFS_PERIOD_ONE, 8'h3c);
    wr(`DTP_OFS_CTRL_ONE, 8'hff);
    rd(`DTP_OFS_CTRL_ONE, 8'hb3);
    repeat (40) @(posedge clk_i);
    chk({15'h0000, oe1}, 16'h0000);
    $display("test registers done");
    config_done_i <= 1'b1;
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 4; k++)
      begin
        ps = (k == 0) ? 16'h0001 : (k == 1) ? 16'h0004 : 16'h0010;
        wr(8'(`DTP_OFS_PERIOD_ONE + ch), 8'h03);
        wr(8'(`DTP_OFS_DUTY_ONE + ch), 8'h02);
        wr(8'(`DTP_OFS_CTRL_ONE + ch), {2'b10, k[1:0], 3'b000, k[0]});
        repeat (64 * ps) @(posedge clk_i);
        chk(ch ? per2 : per1, ps * 16'h0010);
        chk(ch ? hi2 : hi1, (16'h0008 + k[0]) * ps);
      end
    wr(`DTP_OFS_DUTY_ONE, 8'h10);
    wr(`DTP_OFS_CTRL_ONE, 8'h80);
    repeat (64) @(posedge clk_i);
    low = 1'b0;
    repeat (40) @(posedge clk_i) low = low | ~pin1;
    chk({15'h0000, low}, 16'h0000);
    $display("test waveforms done");
    wr(`DTP_OFS_OPTION_TWO, 8'h04);
    tx(4);
    chk({15'h0000, lost}, 16'h0001);
    chk({15'h0000, pin1}, 16'h0000);
    rd(`DTP_OFS_CTRL_ONE, 8'h00);
    rd(`DTP_OFS_CTRL_TWO, 8'h31);
    wr(`DTP_OFS_COUNTER_ONE, 8'h5a);
    rd(`DTP_OFS_COUNTER_ONE, 8'h00);
    @(posedge clk_i) rx_valid_i <= 1'b1;
    @(posedge clk_i) rx_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({15'h0000, lost}, 16'h0000);
    wr(`DTP_OFS_OPTION_TWO, 8'h00);
    tx(5);
    chk({15'h0000, lost}, 16'h0000);
    $display("test loss done");
    wr(`DTP_OFS_DUTY_ONE, 8'h5a);
    wr(`DTP_OFS_PERIOD_ONE, 8'h10);
    @(posedge clk_i) pin_rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    pin_rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(`DTP_OFS_DUTY_ONE, 8'h5a);
    rd(`DTP_OFS_PERIOD_ONE, 8'hff);
    $display("test pin reset done");
    results;
  end
endmodule
`default_nettype wire
